// >>> cte_cfg.svh
`ifndef CTE_CFG_SVH
`define CTE_CFG_SVH

// Accumulator and operand fields
`define CTE_AH          31:16
`define CTE_AL          15:0
`define CTE_AH_LB       23:16
`define CTE_LH          15:8
`define CTE_LB          7:0
`define CTE_IO_ADDR     23:16
`define CTE_ADDR        23:0
`define CTE_SWAP_REG    31:16
`define CTE_SWAP_MEM    15:0

// Fill values
`define CTE_BYTE_ZERO   8'h00
`define CTE_WORD_ZERO   16'h0000
`define CTE_BYTE_ADDR0  8'h00

// Alignment shifts of the shared adder
`define CTE_SH_BYTE     6'h18
`define CTE_SH_WORD     6'h10
`define CTE_SH_LONG     6'h00

// Packed decimal correction
`define CTE_BCD_MAX     5'h09
`define CTE_BCD_FIX     5'h06

// Base cycle counts and the run counter's last value
`define CTE_CYC_BSWAP   6'h03
`define CTE_CYC_WMOVE   6'h02
`define CTE_CYC_WAT_A   6'h02
`define CTE_CYC_ST_AHAL 6'h02
`define CTE_CYC_ST_IMM  6'h03
`define CTE_CYC_RL_DISP 6'h06
`define CTE_CYC_LIMM    6'h03
`define CTE_CYC_LST_PHY 6'h05
`define CTE_CYC_WSWAP   6'h05
`define CTE_CYC_BSUM    6'h02
`define CTE_CYC_DEC     6'h03
`define CTE_CYC_WSUM    6'h02
`define CTE_CYC_WSUMC   6'h02
`define CTE_CYC_WMINB   6'h03
`define CTE_CYC_LREG    6'h05
`define CTE_CYC_LIMM32  6'h04
`define CTE_CYC_INC_BW  6'h02
`define CTE_CYC_INC_L   6'h04
`define CTE_CYC_CMP_BW  6'h02
`define CTE_CYC_CMP_L   6'h03
`define CTE_CYC_DIVB_Z  6'h03
`define CTE_CYC_DIVB_V  6'h06
`define CTE_CYC_DIVB_N  6'h0e
`define CTE_CYC_DIVW_Z  6'h03
`define CTE_CYC_DIVW_V  6'h05
`define CTE_CYC_DIVW_N  6'h15
`define CTE_CNT_LAST    6'h01

`endif

// >>> cte_pkg.sv
package cte_pkg;

    typedef enum logic [4:0] {
        OP_BYTE_SWAP_OP,
        OP_WORD_MOVE_DIR,
        OP_WORD_MOVE_AT_ACC,
        OP_WORD_STORE_UPPER,
        OP_WORD_STORE_IO_IMM,
        OP_WORD_LOAD_LONG_DISP,
        OP_WORD_STORE_LONG_DISP,
        OP_LONG_MOVE_IMM,
        OP_LONG_MOVE_PHYSICAL,
        OP_WORD_SWAP_OP,
        OP_BYTE_SUM_IMM,
        OP_BYTE_SUM_CARRY_DEC,
        OP_BYTE_MINUS_BORROW_DEC,
        OP_WORD_SUM,
        OP_WORD_SUM_CARRY,
        OP_WORD_MINUS_BORROW,
        OP_LONG_SUM_REG,
        OP_LONG_SUM_IMM,
        OP_LONG_MINUS_REG,
        OP_LONG_MINUS_IMM,
        OP_INC_BYTE,
        OP_INC_WORD,
        OP_LONG_INCREMENT,
        OP_DEC_BYTE,
        OP_DEC_WORD,
        OP_LONG_DECREMENT,
        OP_COMPARE_BYTE,
        OP_COMPARE_WORD,
        OP_COMPARE_LONG,
        OP_UNSIGNED_BYTE_QUOTIENT,
        OP_UNSIGNED_WORD_QUOTIENT
    } cte_op_t;

    typedef enum logic [1:0] {
        WID_BYTE,
        WID_WORD,
        WID_LONG
    } cte_wid_t;

    typedef enum logic {
        PH_IDLE,
        PH_RUN
    } cte_phase_t;

    typedef struct packed {
        cte_phase_t  phase;
        logic [5:0]  cnt;
        logic [31:0] acc;
        logic        n;
        logic        z;
        logic        v;
        logic        c;
        logic [31:0] p_acc;
        logic        p_n;
        logic        p_z;
        logic        p_v;
        logic        p_c;
        logic        p_we;
        logic [31:0] p_wd;
        logic [23:0] p_addr;
        logic        done;
        logic        we;
        logic [31:0] wd;
        logic [23:0] addr;
    } cte_state_t;

endpackage

// >>> cte_dp_if.sv
`timescale 1ns/10ps
interface cte_dp_if;
    import cte_pkg::*;

    logic [31:0] alu_a;
    logic [31:0] alu_b;
    logic        alu_cin;
    logic        alu_sub;
    logic        alu_dec;
    cte_wid_t    alu_wid;
    logic [31:0] alu_res;
    logic        alu_n;
    logic        alu_z;
    logic        alu_v;
    logic        alu_c;
    logic        div_wide;
    logic [31:0] div_dividend;
    logic [15:0] div_divisor;
    logic [15:0] div_quo;
    logic [15:0] div_rem;
    logic        div_zero;
    logic        div_ovf;

    modport core (output alu_a, alu_b, alu_cin, alu_sub, alu_dec, alu_wid,
                  output div_wide, div_dividend, div_divisor,
                  input  alu_res, alu_n, alu_z, alu_v, alu_c,
                  input  div_quo, div_rem, div_zero, div_ovf);
    modport alu  (input  alu_a, alu_b, alu_cin, alu_sub, alu_dec, alu_wid,
                  output alu_res, alu_n, alu_z, alu_v, alu_c);
    modport div  (input  div_wide, div_dividend, div_divisor,
                  output div_quo, div_rem, div_zero, div_ovf);
endinterface

// >>> cte_alu.sv
`timescale 1ns/10ps
`include "cte_cfg.svh"
module cte_alu (
    cte_dp_if.alu dp
);
    import cte_pkg::*;

    logic [5:0]  sh;
    logic [31:0] as;
    logic [31:0] bs;
    logic [31:0] cs;
    logic [32:0] sum;
    logic [31:0] bres;
    logic        bv;
    logic [4:0]  lo;
    logic [4:0]  hi;
    logic        lc;
    logic        hc;

    always_comb begin
        case (dp.alu_wid)
            WID_BYTE: sh = `CTE_SH_BYTE;
            WID_WORD: sh = `CTE_SH_WORD;
            default:  sh = `CTE_SH_LONG;
        endcase
        // Align operand MSB to bit 31 so one adder serves all widths
        as = dp.alu_a << sh;
        bs = dp.alu_b << sh;
        cs = {31'h0, dp.alu_cin} << sh;
        if (dp.alu_sub) begin
            sum = {1'b0, as} - {1'b0, bs} - {1'b0, cs};
            bv  = (as[31] != bs[31]) && (sum[31] != as[31]);
        end else begin
            sum = {1'b0, as} + {1'b0, bs} + {1'b0, cs};
            bv  = (as[31] == bs[31]) && (sum[31] != as[31]);
        end
        bres = sum[31:0] >> sh;
        // Packed decimal, byte wide
        if (dp.alu_sub) begin
            lo = {1'b0, dp.alu_a[3:0]} - {1'b0, dp.alu_b[3:0]}
                 - {4'h0, dp.alu_cin};
            lc = lo[4];
            if (lc) begin
                lo = lo - `CTE_BCD_FIX;
            end
            hi = {1'b0, dp.alu_a[7:4]} - {1'b0, dp.alu_b[7:4]} - {4'h0, lc};
            hc = hi[4];
            if (hc) begin
                hi = hi - `CTE_BCD_FIX;
            end
        end else begin
            lo = {1'b0, dp.alu_a[3:0]} + {1'b0, dp.alu_b[3:0]}
                 + {4'h0, dp.alu_cin};
            lc = lo > `CTE_BCD_MAX;
            if (lc) begin
                lo = lo + `CTE_BCD_FIX;
            end
            hi = {1'b0, dp.alu_a[7:4]} + {1'b0, dp.alu_b[7:4]} + {4'h0, lc};
            hc = hi > `CTE_BCD_MAX;
            if (hc) begin
                hi = hi + `CTE_BCD_FIX;
            end
        end
        if (dp.alu_dec) begin
            dp.alu_res = {24'h0, hi[3:0], lo[3:0]};
            dp.alu_c   = hc;
            dp.alu_n   = hi[3];
            dp.alu_z   = {hi[3:0], lo[3:0]} == `CTE_BYTE_ZERO;
        end else begin
            dp.alu_res = bres;
            dp.alu_c   = sum[32];
            dp.alu_n   = sum[31];
            dp.alu_z   = sum[31:0] == 32'h0;
        end
        dp.alu_v = bv;
    end
endmodule // cte_alu

// >>> cte_unsigned_byte_quotient.sv
`timescale 1ns/10ps
`include "cte_cfg.svh"
module cte_unsigned_byte_quotient (
    cte_dp_if.div dp
);
    import cte_pkg::*;

    logic [15:0] dsr;
    logic [31:0] q;
    logic [31:0] r;

    always_comb begin
        if (dp.div_wide) begin
            dsr         = dp.div_divisor;
            dp.div_ovf  = dp.div_dividend[`CTE_AH] >= dsr;
        end else begin
            dsr         = {`CTE_BYTE_ZERO, dp.div_divisor[`CTE_LB]};
            dp.div_ovf  = {`CTE_BYTE_ZERO, dp.div_dividend[`CTE_LH]} >= dsr;
        end
        dp.div_zero = dsr == `CTE_WORD_ZERO;
        // Guard keeps the quotient defined on a zero divisor
        if (dp.div_zero) begin
            q = 32'h0;
            r = 32'h0;
        end else if (dp.div_wide) begin
            q = dp.div_dividend / {16'h0, dsr};
            r = dp.div_dividend % {16'h0, dsr};
        end else begin
            q = {16'h0, dp.div_dividend[`CTE_AL]} / {16'h0, dsr};
            r = {16'h0, dp.div_dividend[`CTE_AL]} % {16'h0, dsr};
        end
        dp.div_quo = q[15:0];
        dp.div_rem = r[15:0];
    end
endmodule // cte_unsigned_byte_quotient

// >>> cte_exec.sv
`timescale 1ns/10ps
`include "cte_cfg.svh"
module cte_exec #(
    parameter int EXW = 5
) (
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    input  wire logic            start_i,
    input  wire cte_pkg::cte_op_t op_i,
    input  wire logic [31:0]     operand_i,
    input  wire logic [31:0]     aux_i,
    input  wire logic [EXW-1:0]  extra_cyc_i,
    output logic                 busy_o,
    output logic                 done_o,
    output logic [31:0]          acc_o,
    output logic                 neg_o,
    output logic                 zero_o,
    output logic                 ovf_o,
    output logic                 carry_o,
    output logic                 wr_o,
    output logic [31:0]          wr_data_o,
    output logic [23:0]          addr_o
);
    import cte_pkg::*;

    cte_dp_if   dp ();
    cte_state_t st;
    cte_state_t nx;
    logic [5:0]  base;
    logic [31:0] na;
    logic        nn;
    logic        nz;
    logic        nv;
    logic        nc;
    logic        wr;
    logic [31:0] wd;
    logic [23:0] ad;

    cte_alu  u_alu  (.dp(dp));
    cte_unsigned_byte_quotient u_unsigned_byte_quotient (.dp(dp));

    always_comb begin
        nx      = st;
        nx.done = 1'b0;
        nx.we   = 1'b0;
        base    = `CTE_CYC_WSUM;
        na      = st.acc;
        nn      = st.n;
        nz      = st.z;
        nv      = st.v;
        nc      = st.c;
        wr      = 1'b0;
        wd      = 32'h0;
        ad      = 24'h0;
        dp.alu_a        = st.acc;
        dp.alu_b        = operand_i;
        dp.alu_cin      = 1'b0;
        dp.alu_sub      = 1'b0;
        dp.alu_dec      = 1'b0;
        dp.alu_wid      = WID_WORD;
        dp.div_wide     = 1'b0;
        dp.div_dividend = st.acc;
        dp.div_divisor  = operand_i[`CTE_AL];
        case (op_i)
            OP_BYTE_SWAP_OP: begin
                na   = {st.acc[`CTE_AH], `CTE_BYTE_ZERO, operand_i[`CTE_LB]};
                wr   = 1'b1;
                wd   = {24'h0, st.acc[`CTE_LB]};
                base = `CTE_CYC_BSWAP;
            end
            OP_WORD_MOVE_DIR: begin
                na   = {st.acc[`CTE_AL], operand_i[`CTE_AL]};
                nn   = operand_i[15];
                nz   = operand_i[`CTE_AL] == `CTE_WORD_ZERO;
                base = `CTE_CYC_WMOVE;
            end
            OP_WORD_MOVE_AT_ACC: begin
                ad   = st.acc[`CTE_ADDR];
                na   = {st.acc[`CTE_AH], operand_i[`CTE_AL]};
                nn   = operand_i[15];
                nz   = operand_i[`CTE_AL] == `CTE_WORD_ZERO;
                base = `CTE_CYC_WAT_A;
            end
            OP_WORD_STORE_UPPER: begin
                ad   = {`CTE_BYTE_ADDR0, st.acc[`CTE_AL]};
                wr   = 1'b1;
                wd   = {16'h0, st.acc[`CTE_AH]};
                nn   = st.acc[31];
                nz   = st.acc[`CTE_AH] == `CTE_WORD_ZERO;
                base = `CTE_CYC_ST_AHAL;
            end
            OP_WORD_STORE_IO_IMM: begin
                ad   = {16'h0, operand_i[`CTE_IO_ADDR]};
                wr   = 1'b1;
                wd   = {16'h0, operand_i[`CTE_AL]};
                base = `CTE_CYC_ST_IMM;
            end
            OP_WORD_LOAD_LONG_DISP: begin
                na   = {st.acc[`CTE_AL], operand_i[`CTE_AL]};
                nn   = operand_i[15];
                nz   = operand_i[`CTE_AL] == `CTE_WORD_ZERO;
                base = `CTE_CYC_RL_DISP;
            end
            OP_WORD_STORE_LONG_DISP: begin
                wr   = 1'b1;
                wd   = {16'h0, st.acc[`CTE_AL]};
                nn   = st.acc[15];
                nz   = st.acc[`CTE_AL] == `CTE_WORD_ZERO;
                base = `CTE_CYC_RL_DISP;
            end
            OP_LONG_MOVE_IMM: begin
                na   = operand_i;
                nn   = operand_i[31];
                nz   = operand_i == 32'h0;
                base = `CTE_CYC_LIMM;
            end
            OP_LONG_MOVE_PHYSICAL: begin
                ad   = st.acc[`CTE_ADDR];
                wr   = 1'b1;
                wd   = operand_i;
                nn   = operand_i[31];
                nz   = operand_i == 32'h0;
                base = `CTE_CYC_LST_PHY;
            end
            OP_WORD_SWAP_OP: begin
                wr   = 1'b1;
                wd   = {operand_i[`CTE_AL], aux_i[`CTE_AL]};
                base = `CTE_CYC_WSWAP;
            end
            OP_BYTE_SUM_IMM, OP_BYTE_SUM_CARRY_DEC,
            OP_BYTE_MINUS_BORROW_DEC: begin
                dp.alu_wid = WID_BYTE;
                base       = `CTE_CYC_BSUM;
                if (op_i != OP_BYTE_SUM_IMM) begin
                    dp.alu_a   = {24'h0, st.acc[`CTE_AH_LB]};
                    dp.alu_b   = {24'h0, st.acc[`CTE_LB]};
                    dp.alu_cin = st.c;
                    dp.alu_dec = 1'b1;
                    dp.alu_sub = op_i == OP_BYTE_MINUS_BORROW_DEC;
                    base       = `CTE_CYC_DEC;
                end
                na = {st.acc[`CTE_AH], `CTE_BYTE_ZERO, dp.alu_res[`CTE_LB]};
                {nn, nz, nv, nc} = {dp.alu_n, dp.alu_z, dp.alu_v, dp.alu_c};
            end
            OP_WORD_SUM, OP_WORD_SUM_CARRY, OP_WORD_MINUS_BORROW: begin
                dp.alu_cin = st.c;
                dp.alu_sub = op_i == OP_WORD_MINUS_BORROW;
                base       = op_i == OP_WORD_MINUS_BORROW ? `CTE_CYC_WMINB
                                                          : `CTE_CYC_WSUMC;
                if (op_i == OP_WORD_SUM) begin
                    dp.alu_a   = {16'h0, st.acc[`CTE_AH]};
                    dp.alu_b   = {16'h0, st.acc[`CTE_AL]};
                    dp.alu_cin = 1'b0;
                    base       = `CTE_CYC_WSUM;
                end
                na = {st.acc[`CTE_AH], dp.alu_res[`CTE_AL]};
                {nn, nz, nv, nc} = {dp.alu_n, dp.alu_z, dp.alu_v, dp.alu_c};
            end
            OP_LONG_SUM_REG, OP_LONG_SUM_IMM,
            OP_LONG_MINUS_REG, OP_LONG_MINUS_IMM: begin
                dp.alu_wid = WID_LONG;
                dp.alu_sub = op_i == OP_LONG_MINUS_REG
                             || op_i == OP_LONG_MINUS_IMM;
                base       = (op_i == OP_LONG_SUM_REG
                              || op_i == OP_LONG_MINUS_REG)
                             ? `CTE_CYC_LREG : `CTE_CYC_LIMM32;
                na = dp.alu_res;
                {nn, nz, nv, nc} = {dp.alu_n, dp.alu_z, dp.alu_v, dp.alu_c};
            end
            OP_INC_BYTE, OP_INC_WORD, OP_LONG_INCREMENT,
            OP_DEC_BYTE, OP_DEC_WORD, OP_LONG_DECREMENT: begin
                dp.alu_a = operand_i;
                dp.alu_b = 32'h1;
                dp.alu_sub = op_i == OP_DEC_BYTE || op_i == OP_DEC_WORD
                             || op_i == OP_LONG_DECREMENT;
                if (op_i == OP_INC_BYTE || op_i == OP_DEC_BYTE) begin
                    dp.alu_wid = WID_BYTE;
                end else if (op_i == OP_INC_WORD || op_i == OP_DEC_WORD) begin
                    dp.alu_wid = WID_WORD;
                end else begin
                    dp.alu_wid = WID_LONG;
                end
                base = dp.alu_wid == WID_LONG ? `CTE_CYC_INC_L
                                              : `CTE_CYC_INC_BW;
                wr   = 1'b1;
                wd   = dp.alu_res;
                {nn, nz, nv} = {dp.alu_n, dp.alu_z, dp.alu_v};
            end
            OP_COMPARE_BYTE, OP_COMPARE_WORD, OP_COMPARE_LONG: begin
                dp.alu_sub = 1'b1;
                if (op_i == OP_COMPARE_BYTE) begin
                    dp.alu_wid = WID_BYTE;
                end else if (op_i == OP_COMPARE_WORD) begin
                    dp.alu_wid = WID_WORD;
                end else begin
                    dp.alu_wid = WID_LONG;
                end
                base = op_i == OP_COMPARE_LONG ? `CTE_CYC_CMP_L
                                               : `CTE_CYC_CMP_BW;
                {nn, nz, nv, nc} = {dp.alu_n, dp.alu_z, dp.alu_v, dp.alu_c};
            end
            OP_UNSIGNED_BYTE_QUOTIENT: begin
                dp.div_dividend = {16'h0, st.acc[`CTE_AH]};
                dp.div_divisor  = {`CTE_BYTE_ZERO, st.acc[`CTE_LB]};
                nv = dp.div_ovf | dp.div_zero;
                nc = dp.div_zero;
                if (dp.div_zero) begin
                    base = `CTE_CYC_DIVB_Z;
                end else if (dp.div_ovf) begin
                    base = `CTE_CYC_DIVB_V;
                end else begin
                    base = `CTE_CYC_DIVB_N;
                    na = {st.acc[31:24], dp.div_rem[`CTE_LB],
                          st.acc[`CTE_LH], dp.div_quo[`CTE_LB]};
                end
            end
            OP_UNSIGNED_WORD_QUOTIENT: begin
                dp.div_wide = 1'b1;
                nv = dp.div_ovf | dp.div_zero;
                nc = dp.div_zero;
                if (dp.div_zero) begin
                    base = `CTE_CYC_DIVW_Z;
                end else if (dp.div_ovf) begin
                    base = `CTE_CYC_DIVW_V;
                end else begin
                    base = `CTE_CYC_DIVW_N;
                    na   = {st.acc[`CTE_AH], dp.div_quo};
                    wr   = 1'b1;
                    wd   = {16'h0, dp.div_rem};
                end
            end
            default: begin
                base = `CTE_CYC_WSUM;
            end
        endcase
        case (st.phase)
            PH_IDLE: begin
                if (start_i) begin
                    nx.phase  = PH_RUN;
                    nx.cnt    = 6'(base + 6'(extra_cyc_i));
                    nx.p_acc  = na;
                    nx.p_n    = nn;
                    nx.p_z    = nz;
                    nx.p_v    = nv;
                    nx.p_c    = nc;
                    nx.p_we   = wr;
                    nx.p_wd   = wd;
                    nx.p_addr = ad;
                end
            end
            PH_RUN: begin
                if (st.cnt == `CTE_CNT_LAST) begin
                    nx.phase = PH_IDLE;
                    nx.acc   = st.p_acc;
                    nx.n     = st.p_n;
                    nx.z     = st.p_z;
                    nx.v     = st.p_v;
                    nx.c     = st.p_c;
                    nx.we    = st.p_we;
                    nx.wd    = st.p_wd;
                    nx.addr  = st.p_addr;
                    nx.done  = 1'b1;
                end else begin
                    nx.cnt = st.cnt - `CTE_CNT_LAST;
                end
            end
            default: begin
                nx.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign busy_o    = st.phase == PH_RUN;
    assign done_o    = st.done;
    assign acc_o     = st.acc;
    assign neg_o     = st.n;
    assign zero_o    = st.z;
    assign ovf_o     = st.v;
    assign carry_o   = st.c;
    assign wr_o      = st.we;
    assign wr_data_o = st.wd;
    assign addr_o    = st.addr;
endmodule // cte_exec

// >>> cte_exec_asserts.sv
`timescale 1ns/10ps
module cte_exec_asserts #(
    parameter int EXW = 5
) (
    input wire logic             clk_i,
    input wire logic             rstn_i,
    input wire logic             start_i,
    input wire cte_pkg::cte_op_t op_i,
    input wire logic [31:0]      operand_i,
    input wire logic [31:0]      aux_i,
    input wire logic [EXW-1:0]   extra_cyc_i,
    input wire logic             busy_o,
    input wire logic             done_o,
    input wire logic [31:0]      acc_o,
    input wire logic             neg_o,
    input wire logic             zero_o,
    input wire logic             ovf_o,
    input wire logic             carry_o,
    input wire logic             wr_o,
    input wire logic [31:0]      wr_data_o,
    input wire logic [23:0]      addr_o
);
    import cte_pkg::*;
    logic           take;
    logic [3:0]     f;
    cte_op_t        lop;
    logic [5:0]     cyc;
    logic [EXW-1:0] lex;
    logic [31:0]    lacc;
    logic [31:0]    lopd;
    assign take = start_i && !busy_o;
    assign f    = {neg_o, zero_o, ovf_o, carry_o};
    // Request as taken, and cycles since
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lop  <= OP_BYTE_SWAP_OP;
            cyc  <= 6'h00;
            lex  <= '0;
            lacc <= 32'h0000_0000;
            lopd <= 32'h0000_0000;
        end else if (take) begin
            lop  <= op_i;
            cyc  <= 6'h00;
            lex  <= extra_cyc_i;
            lacc <= acc_o;
            lopd <= operand_i;
        end else begin
            cyc  <= cyc + 6'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_BSWAP: assert property (done_o && lop == OP_BYTE_SWAP_OP
        |-> cyc == 3 + lex && acc_o[15:0] == {8'h00, lopd[7:0]} && $stable(f))
        else $error("byte swap wrong");
    AST_WMOVE: assert property (done_o && lop == OP_WORD_MOVE_DIR
        |-> cyc == 2 + lex && acc_o == {lacc[15:0], lopd[15:0]}
        && zero_o == (lopd[15:0] == 16'h0000)) else $error("word move wrong");
    AST_ATACC: assert property (done_o && lop == OP_WORD_MOVE_AT_ACC
        |-> acc_o == {lacc[31:16], lopd[15:0]} && neg_o == lopd[15])
        else $error("load via acc wrong");
    AST_IOIMM: assert property (done_o && lop == OP_WORD_STORE_IO_IMM
        |-> cyc == 3 + lex && $stable(f) && wr_o) else $error("io store wrong");
    AST_LDISP: assert property (done_o && lop inside
        {OP_WORD_LOAD_LONG_DISP, OP_WORD_STORE_LONG_DISP} |-> cyc == 6 + lex)
        else $error("disp timing wrong");
    AST_LIMM: assert property (done_o && lop == OP_LONG_MOVE_IMM
        |-> cyc == 3 + lex && acc_o == lopd && neg_o == lopd[31]
        && zero_o == (lopd == 32'h0000_0000)) else $error("long imm wrong");
    AST_INCDEC: assert property (done_o && lop inside {OP_INC_BYTE,
        OP_INC_WORD, OP_LONG_INCREMENT, OP_DEC_BYTE, OP_DEC_WORD,
        OP_LONG_DECREMENT} |-> $stable(carry_o) && wr_o) else $error("inc/dec");
    AST_CMP: assert property (done_o && lop inside {OP_COMPARE_BYTE,
        OP_COMPARE_WORD, OP_COMPARE_LONG} |-> $stable(acc_o) && !wr_o)
        else $error("compare wrote a result");
    AST_DIVZ: assert property (done_o && lop == OP_UNSIGNED_BYTE_QUOTIENT
        && lacc[7:0] == 8'h00 |-> cyc == 3 + lex && ovf_o && carry_o
        && $stable(acc_o)) else $error("zero divisor wrong");
    cover property (take && done_o);
    cover property (done_o && lop == OP_UNSIGNED_WORD_QUOTIENT && !ovf_o);
    cover property (done_o && &lex);
endmodule // cte_exec_asserts
bind cte_exec cte_exec_asserts #(.EXW(EXW)) u_asserts (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .op_i(op_i),
    .operand_i(operand_i), .aux_i(aux_i), .extra_cyc_i(extra_cyc_i),
    .busy_o(busy_o), .done_o(done_o), .acc_o(acc_o), .neg_o(neg_o),
    .zero_o(zero_o), .ovf_o(ovf_o), .carry_o(carry_o), .wr_o(wr_o),
    .wr_data_o(wr_data_o), .addr_o(addr_o));

// >>> tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
    end \
end
module tb;
    import cte_pkg::*;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        start_i = 1'b0;
    cte_op_t     op_i = OP_BYTE_SWAP_OP;
    logic [31:0] operand_i = 32'h0000_0000;
    logic [31:0] aux_i = 32'h0000_0000;
    logic [4:0]  extra_cyc_i = 5'h00;
    logic        busy_o, done_o, neg_o, zero_o, ovf_o, carry_o, wr_o;
    logic [31:0] acc_o, wr_data_o;
    logic [23:0] addr_o;
    int          seed = 22213;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    cte_exec #(.EXW(5)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .start_i(start_i), .op_i(op_i), .operand_i(operand_i), .aux_i(aux_i),
        .extra_cyc_i(extra_cyc_i), .busy_o(busy_o), .done_o(done_o),
        .acc_o(acc_o), .neg_o(neg_o), .zero_o(zero_o), .ovf_o(ovf_o),
        .carry_o(carry_o), .wr_o(wr_o), .wr_data_o(wr_data_o), .addr_o(addr_o));
    always #50 clk_i = ~clk_i;
    function automatic int base(cte_op_t o, logic [31:0] a, logic [31:0] d);
        case (o)
            OP_BYTE_SWAP_OP, OP_WORD_STORE_IO_IMM, OP_LONG_MOVE_IMM,
            OP_BYTE_SUM_CARRY_DEC, OP_BYTE_MINUS_BORROW_DEC,
            OP_WORD_MINUS_BORROW, OP_COMPARE_LONG: return 3;
            OP_WORD_LOAD_LONG_DISP, OP_WORD_STORE_LONG_DISP: return 6;
            OP_LONG_MOVE_PHYSICAL, OP_WORD_SWAP_OP, OP_LONG_SUM_REG,
            OP_LONG_MINUS_REG: return 5;
            OP_LONG_SUM_IMM, OP_LONG_MINUS_IMM, OP_LONG_INCREMENT,
            OP_LONG_DECREMENT: return 4;
            OP_UNSIGNED_BYTE_QUOTIENT: return a[7:0] == 8'h00 ? 3 :
                a[31:16] >= {a[7:0], 8'h00} ? 6 : 14;
            OP_UNSIGNED_WORD_QUOTIENT: return d[15:0] == 16'h0000 ? 3 :
                a[31:16] >= d[15:0] ? 5 : 21;
            default: return 2;
        endcase
    endfunction
    task automatic run(input cte_op_t o, input logic [31:0] d,
                       input logic [4:0] e);
        int          n;
        logic [31:0] a;
        logic        c;
        logic [31:0] r;
        a = acc_o;
        c = carry_o;
        start_i = 1'b1;
        op_i = o;
        operand_i = d;
        aux_i = $random(seed);
        extra_cyc_i = e;
        n = -1;
        do begin
            @(negedge clk_i);
            if (n < 0) begin
                start_i = 1'b0;
                `CHK(busy_o, 1'b1)
            end
            n++;
        end while (done_o !== 1'b1 && n < 60);
        `CHK(n, base(o, a, d) + e)
        case (o)
            OP_WORD_SUM_CARRY: `CHK(acc_o[15:0], a[15:0] + d[15:0] + c)
            OP_WORD_SUM: `CHK(acc_o, {a[31:16], a[31:16] + a[15:0]})
            OP_LONG_MINUS_REG: `CHK(acc_o, a - d)
            OP_WORD_STORE_UPPER:
                `CHK({addr_o, wr_data_o[15:0]}, {8'h00, a[15:0], a[31:16]})
            OP_LONG_MOVE_PHYSICAL:
                `CHK({addr_o, wr_data_o}, {a[23:0], d})
            OP_WORD_MINUS_BORROW:
                `CHK(acc_o[15:0], a[15:0] - d[15:0] - c)
            OP_COMPARE_LONG: begin
                r = a - d;
                `CHK({neg_o, zero_o, carry_o}, {r[31], !r, a < d})
            end
            OP_WORD_SWAP_OP: `CHK(wr_data_o, {d[15:0], aux_i[15:0]})
            OP_BYTE_SUM_IMM: `CHK(acc_o[15:0], {8'h00, 8'(a[7:0] + d[7:0])})
            OP_UNSIGNED_BYTE_QUOTIENT: if (base(o, a, d) == 14) begin
                r = 32'({a[31:16] % a[7:0], 8'(a[31:16] / a[7:0])});
                `CHK({acc_o[23:16], acc_o[7:0]}, r[15:0])
            end
            OP_UNSIGNED_WORD_QUOTIENT: if (base(o, a, d) == 21) begin
                r = {16'(a % d[15:0]), 16'(a / d[15:0])};
                `CHK({wr_data_o[15:0], acc_o[15:0]}, r)
            end
            default: ;
        endcase
    endtask
    task summarize;
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        run(OP_LONG_MOVE_IMM, 32'h0200_0010, 5'h00);
        run(OP_UNSIGNED_BYTE_QUOTIENT, 32'h0000_0000, 5'h00);
        run(OP_LONG_MOVE_IMM, 32'hffff_0001, 5'h00);
        run(OP_UNSIGNED_BYTE_QUOTIENT, 32'h0000_0000, 5'h00);
        run(OP_LONG_MOVE_IMM, 32'h1234_0000, 5'h00);
        run(OP_UNSIGNED_BYTE_QUOTIENT, 32'h0000_0000, 5'h00);
        run(OP_UNSIGNED_WORD_QUOTIENT, 32'h0000_0000, 5'h1f);
        run(OP_UNSIGNED_WORD_QUOTIENT, 32'h0000_4000, 5'h00);
        for (int i = 0; i < 400; i++)
            run(cte_op_t'(i < 31 ? i : {$random(seed)} % 31),
                $random(seed), 5'({$random(seed)} % 4));
        summarize();
    end
endmodule // tb
